// *** verilog/scsp_regs.svh ***
// constants and field layout of the smart card serial control port
// Behaviour
// - host masters link, clock idles high, phase zero
// - strobe falling edge copies shift register to command
// - new command acts at once when strobe low
// - strobe rising edge loads status into shift register
// - idle host keeps load strobe low
// - serial output feeds next device input directly
// - host shifts one byte per chained device
// - strobe asserted only after all bytes shifted
// - strobe low makes output follow live card bit
// - status bit seven reports card detection
// - logic supply grounded forces device shutdown
// - fault starts deactivation within thirty microseconds
// - supply selection changes accepted without power-down
// - host should power down before changing voltage
// - power bits both zero start deactivation
// - fault sets status bit four, pin mirrors inverse
`ifndef SCSP_REGS_SVH
`define SCSP_REGS_SVH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define SCSP_CLK_MHZ 40
`define SCSP_FILTER_NS 5000
`define SCSP_DEACT_MAX_NS 30000
// least time, rounded up to whole cycles
`define SCSP_FILTER_CYC ((`SCSP_FILTER_NS * `SCSP_CLK_MHZ + 999) / 1000)
// host half period of the shift clock, in system cycles
`define SCSP_HALF_CYC 8'h0a
`define SCSP_CNT_ONE 8'h01
`define SCSP_CNT_ZERO 8'h00
`define SCSP_BIT_LAST 3'h7
`define SCSP_BIT_FIRST 3'h0

// ---------------------------------------------------------------------
// command and status fields
// ---------------------------------------------------------------------
`define SCSP_SR_W 8
`define SCSP_PWR_BIT0 0
`define SCSP_PWR_BIT1 1
`define SCSP_FAULT_BIT 4
`define SCSP_CARD_BIT 7
`define SCSP_PWR_OFF 2'h0
`define SCSP_CMD_RESET 8'h00
`define SCSP_STATUS_ZERO 8'h00

// ---------------------------------------------------------------------
// host wishbone registers (byte addresses)
// ---------------------------------------------------------------------
`define SCSP_ADR_DATA 8'h00
`define SCSP_ADR_STAT 8'h04
`define SCSP_ADR_INT 8'h08
`define SCSP_ADR_MASK 8'h0c
// data register: byte in 7:0, raise strobe first, drop strobe after
`define SCSP_DATA_FIRST 8
`define SCSP_DATA_LAST 9
// status register fields
`define SCSP_STAT_BUSY 8
`define SCSP_STAT_FAULTN 9
`define SCSP_STAT_LIVE 10
// interrupt bits
`define SCSP_INT_W 3
`define SCSP_INT_DONE 0
`define SCSP_INT_CARD 1
`define SCSP_INT_FAULT 2
`define SCSP_INT_ZERO 3'h0
`define SCSP_WORD_ZERO 32'h0000_0000

`endif

// *** verilog/scsp_pkg.sv ***
// types used by the host end of the serial control port
package scsp_pkg;

    // host transfer sequencer
    typedef enum logic [2:0] {
        SCSP_H_IDLE,
        SCSP_H_LD_UP,
        SCSP_H_CLK_LO,
        SCSP_H_CLK_HI,
        SCSP_H_TAIL
    } scsp_host_state_t;

    typedef logic [7:0] scsp_byte_t;

endpackage

// *** verilog/scsp_link_if.sv ***
// serial link between the host controller and the card interface device
`timescale 1ns/1ps
interface scsp_link_if;
    logic sclk;
    logic mosi;
    logic miso;
    logic load_strobe_n;
    logic fault_n_drv;
    logic fault_n_oe;
    logic fault_n;

    // open-drain fault line with pull-up
    assign fault_n = (fault_n_oe && !fault_n_drv) ? 1'b0 : 1'b1;

    modport device (
        input sclk,
        input mosi,
        input load_strobe_n,
        output miso,
        output fault_n_drv,
        output fault_n_oe
    );

    modport host (
        output sclk,
        output mosi,
        output load_strobe_n,
        input miso,
        input fault_n
    );
endinterface // scsp_link_if

// *** verilog/scsp_sync.sv ***
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module scsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule // scsp_sync

// *** verilog/scsp_device.sv ***
// card interface device end: serial shift, command and status logic
`timescale 1ns/1ps
`include "scsp_regs.svh"
module scsp_device (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // serial link
    scsp_link_if.device link,
    // card side status pins
    input wire logic card_present_in,
    input wire logic supply_low_in_n,
    input wire logic logic_supply_in,
    // electrical fault event from card supervision logic
    input wire logic fault_event_in,
    // command outputs
    output logic [`SCSP_SR_W-1:0] command_out,
    output logic power_ctrl_bit0_out,
    output logic power_ctrl_bit1_out,
    output logic deactivate_out,
    output logic shutdown_out,
    output logic [`SCSP_SR_W-1:0] status_out
);
    // ---------------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------------
    logic sclk_s;
    logic mosi_s;
    logic ld_s;
    logic card_s;
    logic slow_n_s;
    logic supply_s;

    // every pin except fault_event_in passes two flops before any logic sees it
    scsp_sync #(.W(6)) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in({link.sclk, link.mosi, link.load_strobe_n, card_present_in,
               supply_low_in_n, logic_supply_in}),
        .q_out({sclk_s, mosi_s, ld_s, card_s, slow_n_s, supply_s})
    );

    // ---------------------------------------------------------------------
    // edge detection
    // ---------------------------------------------------------------------
    logic sclk_prev_q;
    logic ld_prev_q;
    logic sclk_fall;
    logic sclk_rise;
    logic ld_fall;
    logic ld_rise;
    logic shutdown_q;

    // previous values start at the synchroniser's reset level; edges
    // seen while shutdown is still high after reset are dropped
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sclk_prev_q <= 1'b0;
            ld_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            ld_prev_q <= ld_s;
        end
    end

    // edges are ignored while the logic supply is off
    assign sclk_fall = sclk_prev_q && !sclk_s && !shutdown_q;
    assign sclk_rise = !sclk_prev_q && sclk_s && !shutdown_q;
    assign ld_fall = ld_prev_q && !ld_s && !shutdown_q;
    assign ld_rise = !ld_prev_q && ld_s && !shutdown_q;

    // ---------------------------------------------------------------------
    // shutdown on missing logic supply
    // ---------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            shutdown_q <= 1'b1;
        end else begin
            shutdown_q <= !supply_s;
        end
    end

    // ---------------------------------------------------------------------
    // shift register
    // ---------------------------------------------------------------------
    logic [`SCSP_SR_W-1:0] shift_q;
    logic din_bit_q;
    logic [`SCSP_SR_W-1:0] status_w;
    logic fault_q;
    logic [`SCSP_SR_W-1:0] cmd_q;

    // input sampled on the leading (falling) edge of the shift clock
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            din_bit_q <= 1'b0;
        end else if (sclk_fall) begin
            din_bit_q <= mosi_s;
        end
    end

    // shift on the trailing edge so output changes away from sampling
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || shutdown_q) begin
            shift_q <= `SCSP_STATUS_ZERO;
        end else if (ld_rise) begin
            shift_q <= status_w;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[`SCSP_SR_W-2:0], din_bit_q};
        end
    end

    // ---------------------------------------------------------------------
    // command register
    // ---------------------------------------------------------------------
    // latched on the strobe's falling edge and applied in the same cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || shutdown_q) begin
            cmd_q <= `SCSP_CMD_RESET;
        end else if (ld_fall) begin
            // any new supply choice is taken as is, no power-down needed
            cmd_q <= shift_q;
        end
    end

    // ---------------------------------------------------------------------
    // fault detection
    // ---------------------------------------------------------------------
    logic powered_w;
    logic elec_fault_w;
    logic removal_w;
    logic [7:0] filt_q;

    assign powered_w = cmd_q[`SCSP_PWR_BIT1:`SCSP_PWR_BIT0] != `SCSP_PWR_OFF;
    assign elec_fault_w = fault_event_in || !slow_n_s;
    // card gone or never there while powered is acted on at once
    assign removal_w = powered_w && !card_s;

    // electrical faults must persist through the filter time, which keeps
    // glitches from bothering the host; the filter is far below the
    // longest allowed delay before deactivation begins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || shutdown_q || !elec_fault_w) begin
            filt_q <= `SCSP_CNT_ZERO;
        end else if (filt_q != 8'(`SCSP_FILTER_CYC)) begin
            filt_q <= filt_q + `SCSP_CNT_ONE;
        end
    end

    // a fault that arrives with a new command still wins over its clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || shutdown_q) begin
            fault_q <= 1'b0;
        end else if (removal_w || filt_q == 8'(`SCSP_FILTER_CYC)) begin
            fault_q <= 1'b1;
        end else if (ld_fall) begin
            fault_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------------
    // status word
    // ---------------------------------------------------------------------
    always_comb begin
        status_w = `SCSP_STATUS_ZERO;
        status_w[`SCSP_CARD_BIT] = card_s;
        status_w[`SCSP_FAULT_BIT] = fault_q;
        status_w[`SCSP_PWR_BIT0] = cmd_q[`SCSP_PWR_BIT0];
        status_w[`SCSP_PWR_BIT1] = cmd_q[`SCSP_PWR_BIT1];
    end

    // ---------------------------------------------------------------------
    // serial output and fault pin
    // ---------------------------------------------------------------------
    logic miso_q;
    logic fault_oe_q;
    logic fault_drv_q;

    // strobe low makes the chain transparent to the live card bit; the
    // output is a plain flop so it drives the next device's input
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || shutdown_q) begin
            miso_q <= 1'b0;
        end else if (!ld_s) begin
            miso_q <= card_s;
        end else begin
            miso_q <= shift_q[`SCSP_SR_W-1];
        end
    end

    // open drain: pulled low while the fault bit is set
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fault_oe_q <= 1'b0;
            fault_drv_q <= 1'b0;
        end else begin
            fault_oe_q <= fault_q && !shutdown_q;
            fault_drv_q <= 1'b0;
        end
    end

    assign link.miso = miso_q;
    assign link.fault_n_oe = fault_oe_q;
    assign link.fault_n_drv = fault_drv_q;

    // ---------------------------------------------------------------------
    // user side outputs
    // ---------------------------------------------------------------------
    logic deact_q;
    logic [`SCSP_SR_W-1:0] status_q;

    // deactivation on an off command or on a latched fault
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            deact_q <= 1'b1;
        end else begin
            deact_q <= !powered_w || fault_q || shutdown_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            status_q <= `SCSP_STATUS_ZERO;
        end else begin
            status_q <= status_w;
        end
    end

    assign command_out = cmd_q;
    assign power_ctrl_bit0_out = cmd_q[`SCSP_PWR_BIT0];
    assign power_ctrl_bit1_out = cmd_q[`SCSP_PWR_BIT1];
    assign deactivate_out = deact_q;
    assign shutdown_out = shutdown_q;
    assign status_out = status_q;

endmodule // scsp_device

// *** verilog/scsp_host.sv ***
// host end: wishbone-controlled serial master for the control port
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "scsp_regs.svh"
module scsp_host (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // interrupt
    output logic irq_out,
    // serial link
    scsp_link_if.host link
);
    // ---------------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------------
    logic miso_s;
    logic fault_n_s;
    logic miso_prev_q;
    logic fault_prev_q;

    scsp_sync #(.W(2)) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in({link.miso, link.fault_n}),
        .q_out({miso_s, fault_n_s})
    );

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            miso_prev_q <= 1'b0;
            fault_prev_q <= 1'b0;
        end else begin
            miso_prev_q <= miso_s;
            fault_prev_q <= fault_n_s;
        end
    end

    // ---------------------------------------------------------------------
    // wishbone decode
    // ---------------------------------------------------------------------
    logic req_w;
    logic wr_w;
    logic ack_q;
    logic start_w;
    scsp_pkg::scsp_host_state_t st_q;

    assign req_w = wb_cyc_in && wb_stb_in && !ack_q;
    assign wr_w = req_w && wb_we_in;
    // a data write while busy is ignored, software polls busy first
    assign start_w = wr_w && wb_adr_in == `SCSP_ADR_DATA && wb_sel_in[0]
        && st_q == scsp_pkg::SCSP_H_IDLE;

    // ---------------------------------------------------------------------
    // transfer sequencer
    // ---------------------------------------------------------------------
    scsp_pkg::scsp_byte_t tx_q;
    scsp_pkg::scsp_byte_t rx_q;
    logic last_q;
    logic [2:0] bit_q;
    logic [7:0] div_q;
    logic sclk_q;
    logic mosi_q;
    logic ld_q;
    logic done_w;
    logic half_w;

    // divider enable: one pulse per half period of the shift clock
    assign half_w = div_q == `SCSP_CNT_ONE;
    assign done_w = st_q == scsp_pkg::SCSP_H_TAIL && half_w;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || st_q == scsp_pkg::SCSP_H_IDLE || half_w) begin
            div_q <= `SCSP_HALF_CYC;
        end else begin
            div_q <= div_q - `SCSP_CNT_ONE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q <= scsp_pkg::SCSP_H_IDLE;
            sclk_q <= 1'b1;
            mosi_q <= 1'b0;
            ld_q <= 1'b0;
            tx_q <= `SCSP_CMD_RESET;
            rx_q <= `SCSP_CMD_RESET;
            last_q <= 1'b0;
            bit_q <= `SCSP_BIT_FIRST;
        end else begin
            unique case (st_q)
                scsp_pkg::SCSP_H_IDLE: begin
                    if (start_w) begin
                        tx_q <= wb_dat_in[7:0];
                        last_q <= wb_dat_in[`SCSP_DATA_LAST];
                        mosi_q <= wb_dat_in[7];
                        bit_q <= `SCSP_BIT_FIRST;
                        // strobe rises to make the device capture status
                        if (wb_dat_in[`SCSP_DATA_FIRST]) begin
                            ld_q <= 1'b1;
                        end
                        st_q <= scsp_pkg::SCSP_H_LD_UP;
                    end
                end
                scsp_pkg::SCSP_H_LD_UP: begin
                    if (half_w) begin
                        sclk_q <= 1'b0;
                        rx_q <= {rx_q[6:0], miso_s};
                        st_q <= scsp_pkg::SCSP_H_CLK_LO;
                    end
                end
                scsp_pkg::SCSP_H_CLK_LO: begin
                    if (half_w) begin
                        sclk_q <= 1'b1;
                        tx_q <= {tx_q[6:0], 1'b0};
                        mosi_q <= tx_q[6];
                        st_q <= scsp_pkg::SCSP_H_CLK_HI;
                    end
                end
                scsp_pkg::SCSP_H_CLK_HI: begin
                    if (half_w) begin
                        if (bit_q == `SCSP_BIT_LAST) begin
                            st_q <= scsp_pkg::SCSP_H_TAIL;
                        end else begin
                            bit_q <= bit_q + 3'h1;
                            sclk_q <= 1'b0;
                            rx_q <= {rx_q[6:0], miso_s};
                            st_q <= scsp_pkg::SCSP_H_CLK_LO;
                        end
                    end
                end
                scsp_pkg::SCSP_H_TAIL: begin
                    if (half_w) begin
                        // strobe drops only after the chain's last byte
                        if (last_q) begin
                            ld_q <= 1'b0;
                        end
                        st_q <= scsp_pkg::SCSP_H_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.mosi = mosi_q;
    // ld_q is the strobe pin level itself, so the idle strobe rests low
    assign link.load_strobe_n = ld_q;

    // ---------------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------------
    logic [`SCSP_INT_W-1:0] int_q;
    logic [`SCSP_INT_W-1:0] mask_q;
    logic [`SCSP_INT_W-1:0] ev_w;
    logic [`SCSP_INT_W-1:0] clr_w;
    logic irq_q;

    always_comb begin
        ev_w = `SCSP_INT_ZERO;
        ev_w[`SCSP_INT_DONE] = done_w;
        // live card bit changes only mean something with strobe low
        ev_w[`SCSP_INT_CARD] = !ld_q && st_q == scsp_pkg::SCSP_H_IDLE
            && miso_s != miso_prev_q;
        ev_w[`SCSP_INT_FAULT] = fault_prev_q && !fault_n_s;
        clr_w = `SCSP_INT_ZERO;
        if (wr_w && wb_adr_in == `SCSP_ADR_INT && wb_sel_in[0]) begin
            clr_w = wb_dat_in[`SCSP_INT_W-1:0];
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            int_q <= `SCSP_INT_ZERO;
        end else begin
            int_q <= (int_q & ~clr_w) | ev_w;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mask_q <= `SCSP_INT_ZERO;
        end else if (wr_w && wb_adr_in == `SCSP_ADR_MASK && wb_sel_in[0]) begin
            mask_q <= wb_dat_in[`SCSP_INT_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_q & mask_q);
        end
    end

    assign irq_out = irq_q;

    // ---------------------------------------------------------------------
    // wishbone answer
    // ---------------------------------------------------------------------
    logic [31:0] rd_q;

    // one wait state; ack drops in the cycle after it was given
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
            rd_q <= `SCSP_WORD_ZERO;
        end else begin
            ack_q <= req_w;
            rd_q <= `SCSP_WORD_ZERO;
            if (req_w && !wb_we_in) begin
                unique case (wb_adr_in)
                    `SCSP_ADR_STAT: begin
                        rd_q[7:0] <= rx_q;
                        rd_q[`SCSP_STAT_BUSY] <=
                            st_q != scsp_pkg::SCSP_H_IDLE;
                        rd_q[`SCSP_STAT_FAULTN] <= fault_n_s;
                        rd_q[`SCSP_STAT_LIVE] <= miso_s;
                    end
                    `SCSP_ADR_INT: rd_q[`SCSP_INT_W-1:0] <= int_q;
                    `SCSP_ADR_MASK: rd_q[`SCSP_INT_W-1:0] <= mask_q;
                    default: rd_q <= `SCSP_WORD_ZERO;
                endcase
            end
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rd_q;

endmodule // scsp_host

// *** test/scsp_link_asserts.sv ***
// concurrent checks on the serial link and the device command side
`timescale 1ns/1ps
module scsp_link_asserts (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // link wires
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic load_strobe_n,
    input wire logic fault_n,
    // device pins
    input wire logic card_present_in,
    input wire logic logic_supply_in,
    input wire logic [7:0] command_out,
    input wire logic [7:0] status_out,
    input wire logic deactivate_out,
    input wire logic shutdown_out
);
    // ------------------------------------------------------------
    // reference shift register and assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] bits_q;
    // mosi is stable over the low half, so the falling edge is safe
    always_ff @(posedge clk_in) begin
        if ($fell(sclk)) begin
            bits_q <= {bits_q[6:0], mosi};
        end
    end
    idle_high_a: assert property (!load_strobe_n |-> sclk)
        else $error("shift clock not idle high");
    clk_gate_a: assert property ($changed(sclk) |-> load_strobe_n)
        else $error("shift clock moved with strobe low");
    half_period_a: assert property ($fell(sclk) |-> !sclk[*8])
        else $error("shift clock low half too short");
    cmd_latch_a: assert property ($fell(load_strobe_n) ##0 logic_supply_in
        |-> ##[2:6] command_out == bits_q)
        else $error("command not taken from shift register");
    cmd_hold_a: assert property (load_strobe_n
        && $past(load_strobe_n, 8) |-> $stable(command_out))
        else $error("command changed without strobe fall");
    live_card_a: assert property ((!load_strobe_n && logic_supply_in
        && $stable(card_present_in))[*8] |-> miso == card_present_in)
        else $error("serial output not following card bit");
    card_bit_a: assert property ((logic_supply_in
        && $stable(card_present_in))[*6] |-> status_out[7] == card_present_in)
        else $error("status card bit wrong");
    fault_pin_a: assert property ($rose(status_out[4]) |-> ##[0:2] !fault_n)
        else $error("fault line not low with fault bit");
    deact_a: assert property (command_out[1:0] == 2'h0
        |-> ##[0:2] deactivate_out)
        else $error("power bits off without deactivation");
    shut_a: assert property ((!logic_supply_in)[*6] |-> shutdown_out)
        else $error("no shutdown with logic supply absent");
    cover property ($fell(load_strobe_n));
    cover property ($rose(status_out[4]));
    cover property ($rose(shutdown_out));
endmodule // scsp_link_asserts

// *** test/smart_card_serial_control_port_tb.sv ***
// self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
`include "scsp_regs.svh"
module smart_card_serial_control_port_tb;
    // ------------------------------------------------------------
    // signals, instances and tasks
    // ------------------------------------------------------------
    logic clk_in = 1'b0, rst_n_in = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, cmd, stat, prev = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ack, irq, p0, p1, deact, shut;
    logic card = 1'b1, sup_n = 1'b1, lsup = 1'b1, fev = 1'b0;
    int error_cnt = 0, checked = 0;
    // rows: expected deactivate level above the command byte
    logic [8:0] rows [4] = '{9'h001, 9'h002, 9'h0fe, 9'h100};
    initial forever #12.5 clk_in = ~clk_in;
    scsp_link_if link ();
    scsp_host scsp_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .irq_out(irq), .link(link));
    scsp_device scsp_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .link(link), .card_present_in(card), .supply_low_in_n(sup_n),
        .logic_supply_in(lsup), .fault_event_in(fev), .command_out(cmd),
        .power_ctrl_bit0_out(p0), .power_ctrl_bit1_out(p1),
        .deactivate_out(deact), .shutdown_out(shut), .status_out(stat));
    scsp_link_asserts scsp_link_asserts_inst (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .sclk(link.sclk), .mosi(link.mosi),
        .miso(link.miso), .load_strobe_n(link.load_strobe_n),
        .fault_n(link.fault_n), .card_present_in(card),
        .logic_supply_in(lsup), .command_out(cmd), .status_out(stat),
        .deactivate_out(deact), .shutdown_out(shut));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; the answer time is left to the slave
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_in); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_in);
    endtask
    // one whole byte with strobe raised before and dropped after
    task automatic send(input logic [7:0] b);
        wb(1'b1, `SCSP_ADR_DATA, {22'h0, 2'h3, b});
        do wb(1'b0, `SCSP_ADR_STAT, 32'h0); while (rd[8] !== 1'b0);
        repeat (8) @(posedge clk_in);
    endtask
    task automatic results();
        $display("checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // a hung handshake would stall the run, so cut it short
    initial begin
        repeat (40000) @(posedge clk_in);
        error_cnt++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        chk(32'(cmd), 32'h0);
        chk(32'(deact), 32'h1);
        wb(1'b1, `SCSP_ADR_MASK, 32'h7);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0); // unmapped place reads zero
        foreach (rows[i]) begin
            send(rows[i][7:0]);
            chk(32'(rd[7:0]), {24'h0, card, 5'h0, prev[1:0]});
            chk(32'(cmd), 32'(rows[i][7:0]));
            chk(32'({p1, p0}), 32'(rows[i][1:0]));
            chk(32'(deact), 32'(rows[i][8]));
            chk(32'(irq), 32'h1); // done event raises the line
            wb(1'b1, `SCSP_ADR_INT, 32'h7);
            @(posedge clk_in);
            chk(32'(irq), 32'h0); // cleared by writing ones
            prev = rows[i][7:0];
        end
        // card removal seen live while the strobe rests low
        card <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk(32'(link.miso), 32'h0);
        chk(32'(stat[7]), 32'h0);
        wb(1'b0, `SCSP_ADR_INT, 32'h0);
        chk(rd, 32'h2);
        card <= 1'b1;
        repeat (10) @(posedge clk_in);
        send(8'h03);
        // fault longer than the filter, then read it back
        fev <= 1'b1;
        repeat (300) @(posedge clk_in);
        fev <= 1'b0;
        chk(32'(link.fault_n), 32'h0);
        chk(32'(deact), 32'h1);
        wb(1'b0, `SCSP_ADR_INT, 32'h0);
        chk(32'(rd[2]), 32'h1);
        send(8'h00);
        chk(32'(rd[7:0]), 32'h93);
        lsup <= 1'b0;
        repeat (8) @(posedge clk_in);
        chk(32'(shut), 32'h1);
        chk(32'(deact), 32'h1);
        results();
    end
endmodule // smart_card_serial_control_port_tb
